/* File: verilog/mpw_consts.svh */
// register offsets, field positions and encodings of the pwm unit
// assumes: included by its bare name from the pwm unit sources
`ifndef MPW_CONSTS_SVH
`define MPW_CONSTS_SVH
`define MPW_GCTL 8'h00
`define MPW_GSYNC 8'h04
`define MPW_GUPD 8'h08
`define MPW_OUTEN 8'h0C
`define MPW_INV 8'h10
`define MPW_FLTEN 8'h14
`define MPW_FLTVAL 8'h18
`define MPW_FLTPOL 8'h1C
`define MPW_FLTSEL 8'h20
`define MPW_FLTFILT 8'h24
`define MPW_ISTAT 8'h28
`define MPW_IMASK 8'h2C
`define MPW_FSTAT 8'h30
`define MPW_PAGE_GLOB 4'h0
`define MPW_PAGE_GEN 4'h1
`define MPW_G_CTL 6'h00
`define MPW_G_LOAD 6'h04
`define MPW_G_CMPA 6'h08
`define MPW_G_CMPB 6'h0C
`define MPW_G_GENA 6'h10
`define MPW_G_GENB 6'h14
`define MPW_G_DB 6'h18
`define MPW_G_EVSEL 6'h1C
`define MPW_G_COUNT 6'h20
`define MPW_C_EN 0
`define MPW_C_UD 1
`define MPW_C_LSYNC 2
`define MPW_C_CSYNC 3
`define MPW_C_DBEN 4
`define MPW_GCTL_EXT 4
`define MPW_IST_FLT 4
`define MPW_ACT_NONE 2'h0
`define MPW_ACT_INV 2'h1
`define MPW_ACT_LOW 2'h2
`define MPW_ACT_HIGH 2'h3
`define MPW_RST_LOAD 16'h0000
`define MPW_RST_FILT 8'h00
`endif

/* File: verilog/mpw_pkg.sv */
// types shared by the pwm unit modules
// assumes: compiled before every module of the unit
package mpw_pkg;
    typedef logic [15:0] mpw_cnt_t;
    typedef enum logic {MPW_UP, MPW_DOWN} mpw_dir_t;
endpackage

/* File: verilog/mpw_gen.sv */
// one pwm generator: counter, comparators, action logic, dead band
// assumes: shadow values and update permissions come from mpw_top
`timescale 1ns/10ps
`default_nettype none
`include "mpw_consts.svh"
module mpw_gen
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] ctl,
    input wire logic upd_ok,
    input wire logic upd_force,
    input wire logic restart,
    input wire mpw_pkg::mpw_cnt_t load_sh,
    input wire mpw_pkg::mpw_cnt_t cmpa_sh,
    input wire mpw_pkg::mpw_cnt_t cmpb_sh,
    input wire logic [11:0] act_a,
    input wire logic [11:0] act_b,
    input wire logic [15:0] db,
    input wire logic [13:0] evsel,
    output logic out_a,
    output logic out_b,
    output logic ev_int,
    output logic ev_adc,
    output logic zero_now,
    output logic applied,
    output mpw_pkg::mpw_cnt_t count
);
    import mpw_pkg::*;
    mpw_cnt_t cnt_r, cnt_nxt, load_r, cmpa_r, cmpb_r;
    mpw_dir_t dir_r, dir_nxt;
    logic pwm_a_r, pwm_b_r, pwm_a_nxt, pwm_b_nxt;
    logic [7:0] dbc_r;
    logic [5:0] ev;
    wire en = ctl[`MPW_C_EN];
    wire ud = ctl[`MPW_C_UD];
    wire at_zero = (cnt_r == 16'h0000);
    wire at_load = (cnt_r == load_r);
    wire up = ud && (dir_r == MPW_UP);
    wire hit_a = (cnt_r == cmpa_r);
    wire hit_b = (cnt_r == cmpb_r);
    // update at own zero keeps periods whole; extended force lands at generator 0 zero
    wire apply = (upd_ok && at_zero && en) || upd_force; // RULE_17
    assign zero_now = at_zero && en;
    assign count = cnt_r;
    assign ev = {hit_b && !up, hit_b && up, hit_a && !up, hit_a && up,
                 at_load, at_zero} & {6{en}}; // RULE_04 RULE_05

    function automatic logic act_fn(input logic [5:0] e,
                                    input logic [11:0] act,
                                    input logic cur);
        logic v;
        v = cur;
        for (int k = 0; k < 6; k++)
        begin
            if (e[k])
            begin
                unique case (act[2*k +: 2])
                    `MPW_ACT_NONE: v = v;
                    `MPW_ACT_INV: v = ~v;
                    `MPW_ACT_LOW: v = 1'b0;
                    `MPW_ACT_HIGH: v = 1'b1;
                endcase
            end
        end
        return v;
    endfunction

    assign pwm_a_nxt = act_fn(ev, act_a, pwm_a_r); // RULE_06
    assign pwm_b_nxt = act_fn(ev, act_b, pwm_b_r); // RULE_06

    always_comb
    begin
        cnt_nxt = cnt_r - 16'h0001;
        dir_nxt = dir_r;
        if (load_r == 16'h0000)
            cnt_nxt = 16'h0000;
        else if (!ud)
        begin
            if (at_zero)
                cnt_nxt = load_r; // RULE_16
        end
        else if (dir_r == MPW_UP)
        begin
            if (cnt_r >= load_r)
                dir_nxt = MPW_DOWN; // RULE_16
            else
                cnt_nxt = cnt_r + 16'h0001;
        end
        else if (at_zero)
        begin
            dir_nxt = MPW_UP;
            cnt_nxt = 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 16'h0000;
            dir_r <= MPW_UP;
        end
        else if (restart)
        begin
            cnt_r <= 16'h0000; // RULE_13
            dir_r <= MPW_UP;
        end
        else if (en)
        begin
            cnt_r <= cnt_nxt; // RULE_02
            dir_r <= dir_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            load_r <= `MPW_RST_LOAD;
            cmpa_r <= 16'h0000;
            cmpb_r <= 16'h0000;
            applied <= 1'b0;
        end
        else
        begin
            if (!ctl[`MPW_C_LSYNC] || apply)
                load_r <= load_sh; // RULE_03
            if (!ctl[`MPW_C_CSYNC] || apply)
            begin
                cmpa_r <= cmpa_sh; // RULE_05
                cmpb_r <= cmpb_sh;
            end
            applied <= apply;
        end
    end

    // dead band counts cycles since the last edge of the a waveform
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwm_a_r <= 1'b0;
            pwm_b_r <= 1'b0;
            dbc_r <= 8'h00;
            out_a <= 1'b0;
            out_b <= 1'b0;
            ev_int <= 1'b0;
            ev_adc <= 1'b0;
        end
        else
        begin
            pwm_a_r <= pwm_a_nxt;
            pwm_b_r <= pwm_b_nxt;
            if (pwm_a_nxt != pwm_a_r)
                dbc_r <= 8'h00;
            else if (dbc_r != 8'hFF)
                dbc_r <= dbc_r + 8'h01;
            if (ctl[`MPW_C_DBEN])
            begin
                out_a <= pwm_a_r && (dbc_r >= db[7:0]); // RULE_07
                out_b <= !pwm_a_r && (dbc_r >= db[15:8]); // RULE_07
            end
            else
            begin
                out_a <= pwm_a_r; // RULE_08
                out_b <= pwm_b_r; // RULE_08
            end
            ev_int <= |(ev & evsel[5:0]); // RULE_09
            ev_adc <= |(ev & evsel[13:8]); // RULE_09
        end
    end

    AST_ZERO_EVENT: // RULE_04
    assert property (@(posedge pclk) disable iff (!presetn)
        (at_zero && en && evsel[0]) |=> ev_int)
    else $error("zero event did not raise interrupt pulse");

    AST_DOWN_RELOAD: // RULE_16
    assert property (@(posedge pclk) disable iff (!presetn)
        (en && !ud && at_zero && !restart && !apply && load_r != 16'h0000)
        |=> (cnt_r == $past(load_r)))
    else $error("down counter did not reload");

    AST_UPDOWN_STEP: // RULE_16
    assert property (@(posedge pclk) disable iff (!presetn)
        (en && up && !restart && (cnt_r < load_r))
        |=> (cnt_r == $past(cnt_r) + 16'h0001))
    else $error("up/down counter did not step up");

    AST_RESTART: // RULE_13
    assert property (@(posedge pclk) disable iff (!presetn)
        restart |=> (cnt_r == 16'h0000))
    else $error("restart did not clear counter");

    AST_BYPASS: // RULE_08
    assert property (@(posedge pclk) disable iff (!presetn)
        !ctl[`MPW_C_DBEN] |=> (out_a == $past(pwm_a_r))
                              && (out_b == $past(pwm_b_r)))
    else $error("bypassed dead band altered waveform");

    AST_SYNC_LOAD: // RULE_17
    assert property (@(posedge pclk) disable iff (!presetn)
        (ctl[`MPW_C_LSYNC] && !apply) |=> $stable(load_r))
    else $error("synchronised load changed outside zero");
endmodule // mpw_gen
`default_nettype wire

/* File: verilog/mpw_top.sv */
// pwm unit top: apb registers, four generators, fault and output control
// assumes: fault pins are asynchronous; apb master on pclk
//
// Summary of operation
// RULE_01: four generators, two outputs each, eight total
// RULE_02: 16-bit counter, down or up/down
// RULE_03: load value sets period, optional deferred update
// RULE_04: event pulses at zero and load
// RULE_05: two comparators with optionally synchronised values
// RULE_06: actions on events build each waveform
// RULE_07: independent pair or complementary with dead band
// RULE_08: dead band bypass passes waveforms unchanged
// RULE_09: selected events raise interrupt or adc trigger
// RULE_10: per output enable and polarity inversion
// RULE_11: four fault inputs, per output fast shutdown
// RULE_12: combined faults, programmable polarity, input filter
// RULE_13: selected counters restart together
// RULE_14: grouped pending updates, plus extended mode
// RULE_15: interrupt summary shows requesting generator
// RULE_16: down reloads at zero; up/down bounces
// RULE_17: synchronised updates apply only at zero; extended mode applies them at generator 0 zero, even to a paused generator
// RULE_18: fault forces safe level over inversion
`timescale 1ns/10ps
`default_nettype none
`include "mpw_consts.svh"
module mpw_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] fault_in,
    output logic [7:0] pwm_out,
    output logic [3:0] adc_trig,
    output logic irq
);
    import mpw_pkg::*;
    logic [4:0] gctl_r, istat_r, imask_r, istat_nxt;
    logic [7:0] outen_r, inv_r, flten_r, fltval_r, filt_r;
    logic [3:0] fltpol_r, fltsel_r, restart_r, arm_r, arm_nxt;
    logic [3:0] s1_r, s2_r, s3_r, stab_r, fout_r;
    logic [7:0] fcnt_r [4];
    logic [4:0] ctl_r [4];
    mpw_cnt_t load_r [4];
    mpw_cnt_t cmpa_r [4];
    mpw_cnt_t cmpb_r [4];
    mpw_cnt_t cnt_w [4];
    logic [11:0] gena_r [4];
    logic [11:0] genb_r [4];
    logic [15:0] db_r [4];
    logic [13:0] evsel_r [4];
    logic [31:0] gen_rd [4];
    logic [7:0] gen_out;
    logic [3:0] gen_int, gen_adc, zero_w, applied_w, upd_ok_w, force_w;
    logic fault_prev_r;

    // access phase always completes in its first cycle
    wire setup = psel && !penable;
    wire wr = psel && penable && pready && pwrite;
    wire glob = (paddr[11:8] == `MPW_PAGE_GLOB);
    wire gpage = (paddr[11:8] == `MPW_PAGE_GEN);
    wire [7:0] go = paddr[7:0];
    wire [5:0] ro = paddr[5:0];
    wire [1:0] gi = paddr[7:6];
    wire ro_ok = (ro <= `MPW_G_COUNT) && (ro[1:0] == 2'h0);
    wire glob_ok = glob && (go <= `MPW_FSTAT) && (go[1:0] == 2'h0);
    wire hit = glob_ok || (gpage && ro_ok);
    wire gw = wr && glob;
    wire w_gsync = gw && (go == `MPW_GSYNC);
    wire w_gupd = gw && (go == `MPW_GUPD);
    wire w_istat = gw && (go == `MPW_ISTAT);
    wire ext = gctl_r[`MPW_GCTL_EXT];
    wire fault_act = |(fout_r & fltsel_r); // RULE_12
    wire fault_rise = fault_act && !fault_prev_r;
    wire [31:0] glob_rd =
        (go == `MPW_GCTL) ? {27'h000_0000, gctl_r} :
        (go == `MPW_GUPD) ? {28'h000_0000, arm_r} :
        (go == `MPW_OUTEN) ? {24'h00_0000, outen_r} :
        (go == `MPW_INV) ? {24'h00_0000, inv_r} :
        (go == `MPW_FLTEN) ? {24'h00_0000, flten_r} :
        (go == `MPW_FLTVAL) ? {24'h00_0000, fltval_r} :
        (go == `MPW_FLTPOL) ? {28'h000_0000, fltpol_r} :
        (go == `MPW_FLTSEL) ? {28'h000_0000, fltsel_r} :
        (go == `MPW_FLTFILT) ? {24'h00_0000, filt_r} :
        (go == `MPW_ISTAT) ? {27'h000_0000, istat_r} : // RULE_15
        (go == `MPW_IMASK) ? {27'h000_0000, imask_r} :
        (go == `MPW_FSTAT) ? {27'h000_0000, fault_act, fout_r} :
        32'h0000_0000;
    wire [31:0] rd = !hit ? 32'h0000_0000 : glob ? glob_rd : gen_rd[gi];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !hit;
            prdata <= (setup && !pwrite) ? rd : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gctl_r <= 5'h00;
            outen_r <= 8'h00;
            inv_r <= 8'h00;
            flten_r <= 8'h00;
            fltval_r <= 8'h00;
            fltpol_r <= 4'h0;
            fltsel_r <= 4'h0;
            filt_r <= `MPW_RST_FILT;
            imask_r <= 5'h00;
        end
        else if (gw)
        begin
            if (go == `MPW_GCTL)
                gctl_r <= pwdata[4:0];
            if (go == `MPW_OUTEN)
                outen_r <= pwdata[7:0];
            if (go == `MPW_INV)
                inv_r <= pwdata[7:0];
            if (go == `MPW_FLTEN)
                flten_r <= pwdata[7:0];
            if (go == `MPW_FLTVAL)
                fltval_r <= pwdata[7:0];
            if (go == `MPW_FLTPOL)
                fltpol_r <= pwdata[3:0];
            if (go == `MPW_FLTSEL)
                fltsel_r <= pwdata[3:0];
            if (go == `MPW_FLTFILT)
                filt_r <= pwdata[7:0];
            if (go == `MPW_IMASK)
                imask_r <= pwdata[4:0];
        end
    end

    // hardware set beats software clear on istat; software arm beats hardware clear on arm
    assign istat_nxt = (istat_r & ~(w_istat ? pwdata[4:0] : 5'h00))
                       | {fault_rise, gen_int};
    assign arm_nxt = (arm_r & ~applied_w) | (w_gupd ? pwdata[3:0] : 4'h0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            istat_r <= 5'h00;
            irq <= 1'b0;
            arm_r <= 4'h0;
            restart_r <= 4'h0;
            fault_prev_r <= 1'b0;
            adc_trig <= 4'h0;
        end
        else
        begin
            istat_r <= istat_nxt; // RULE_15
            irq <= |(istat_r & imask_r);
            arm_r <= arm_nxt; // RULE_14
            restart_r <= w_gsync ? pwdata[3:0] : 4'h0; // RULE_13
            fault_prev_r <= fault_act;
            adc_trig <= gen_adc; // RULE_09
        end
    end

    // fault pins: three stages, level accepted once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
            s3_r <= 4'h0;
            stab_r <= 4'h0;
        end
        else
        begin
            s1_r <= fault_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            stab_r <= (stab_r & ~(s2_r ~^ s3_r)) | (s3_r & (s2_r ~^ s3_r));
        end
    end

    for (genvar f = 0; f < 4; f++)
    begin : g_flt
        // filter adds filt_r cycles of latency; zero gives fastest trip
        wire lvl = stab_r[f] ^ fltpol_r[f]; // RULE_12
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                fcnt_r[f] <= 8'h00;
                fout_r[f] <= 1'b0;
            end
            else if (lvl == fout_r[f])
                fcnt_r[f] <= 8'h00;
            else if (fcnt_r[f] >= filt_r)
            begin
                fout_r[f] <= lvl; // RULE_12
                fcnt_r[f] <= 8'h00;
            end
            else
                fcnt_r[f] <= fcnt_r[f] + 8'h01;
        end

        AST_FILTER: // RULE_12
        assert property (@(posedge pclk) disable iff (!presetn)
            !$stable(fout_r[f]) |-> ($past(fcnt_r[f]) >= $past(filt_r)))
        else $error("fault level passed filter too early");
    end

    for (genvar g = 0; g < 4; g++)
    begin : g_gen
        wire gsel = wr && gpage && (gi == g);
        assign gen_rd[g] =
            (ro == `MPW_G_CTL) ? {27'h000_0000, ctl_r[g]} :
            (ro == `MPW_G_LOAD) ? {16'h0000, load_r[g]} :
            (ro == `MPW_G_CMPA) ? {16'h0000, cmpa_r[g]} :
            (ro == `MPW_G_CMPB) ? {16'h0000, cmpb_r[g]} :
            (ro == `MPW_G_GENA) ? {20'h0_0000, gena_r[g]} :
            (ro == `MPW_G_GENB) ? {20'h0_0000, genb_r[g]} :
            (ro == `MPW_G_DB) ? {16'h0000, db_r[g]} :
            (ro == `MPW_G_EVSEL) ? {18'h0_0000, evsel_r[g]} :
            (ro == `MPW_G_COUNT) ? {16'h0000, cnt_w[g]} :
            32'h0000_0000;
        // grouped mode waits for the arm; extended aligns to generator 0
        assign upd_ok_w[g] = !gctl_r[g] || (arm_r[g] && !ext); // RULE_14
        assign force_w[g] = gctl_r[g] && ext && arm_r[g] && zero_w[0];

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                ctl_r[g] <= 5'h00;
                load_r[g] <= `MPW_RST_LOAD;
                cmpa_r[g] <= 16'h0000;
                cmpb_r[g] <= 16'h0000;
                gena_r[g] <= 12'h000;
                genb_r[g] <= 12'h000;
                db_r[g] <= 16'h0000;
                evsel_r[g] <= 14'h0000;
            end
            else if (gsel)
            begin
                if (ro == `MPW_G_CTL)
                    ctl_r[g] <= pwdata[4:0];
                if (ro == `MPW_G_LOAD)
                    load_r[g] <= pwdata[15:0];
                if (ro == `MPW_G_CMPA)
                    cmpa_r[g] <= pwdata[15:0];
                if (ro == `MPW_G_CMPB)
                    cmpb_r[g] <= pwdata[15:0];
                if (ro == `MPW_G_GENA)
                    gena_r[g] <= pwdata[11:0];
                if (ro == `MPW_G_GENB)
                    genb_r[g] <= pwdata[11:0];
                if (ro == `MPW_G_DB)
                    db_r[g] <= pwdata[15:0];
                if (ro == `MPW_G_EVSEL)
                    evsel_r[g] <= pwdata[13:0];
            end
        end

        mpw_gen u_gen // RULE_01
        (
            .pclk(pclk),
            .presetn(presetn),
            .ctl(ctl_r[g]),
            .upd_ok(upd_ok_w[g]),
            .upd_force(force_w[g]),
            .restart(restart_r[g]),
            .load_sh(load_r[g]),
            .cmpa_sh(cmpa_r[g]),
            .cmpb_sh(cmpb_r[g]),
            .act_a(gena_r[g]),
            .act_b(genb_r[g]),
            .db(db_r[g]),
            .evsel(evsel_r[g]),
            .out_a(gen_out[2*g]),
            .out_b(gen_out[2*g+1]),
            .ev_int(gen_int[g]),
            .ev_adc(gen_adc[g]),
            .zero_now(zero_w[g]),
            .applied(applied_w[g]),
            .count(cnt_w[g])
        );

        AST_INT_SET: // RULE_09
        assert property (@(posedge pclk) disable iff (!presetn)
            gen_int[g] |=> istat_r[g])
        else $error("generator event did not set status");
    end

    for (genvar i = 0; i < 8; i++)
    begin : g_out
        wire blk = fault_act && flten_r[i]; // RULE_11
        wire lvl = blk ? fltval_r[i] : (gen_out[i] ^ inv_r[i]); // RULE_18
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                pwm_out[i] <= 1'b0;
            else
                pwm_out[i] <= outen_r[i] && lvl; // RULE_10
        end

        AST_FAULT_SAFE: // RULE_18
        assert property (@(posedge pclk) disable iff (!presetn)
            (fault_act && flten_r[i] && outen_r[i])
            |=> (pwm_out[i] == $past(fltval_r[i])))
        else $error("faulted output not at safe level");

        AST_DISABLED: // RULE_10
        assert property (@(posedge pclk) disable iff (!presetn)
            !outen_r[i] |=> !pwm_out[i])
        else $error("disabled output driven high");

        AST_POLARITY: // RULE_10
        assert property (@(posedge pclk) disable iff (!presetn)
            (outen_r[i] && !blk)
            |=> (pwm_out[i] == ($past(gen_out[i]) ^ $past(inv_r[i]))))
        else $error("output polarity wrong");
    end

    AST_IRQ: // RULE_15
    assert property (@(posedge pclk) disable iff (!presetn)
        (|(istat_r & imask_r)) |=> irq)
    else $error("unmasked status did not raise interrupt");

    AST_ARM_HOLD: // RULE_14
    assert property (@(posedge pclk) disable iff (!presetn)
        (arm_r[0] && !applied_w[0]) |=> arm_r[0])
    else $error("armed update dropped before apply");
endmodule // mpw_top
`default_nettype wire

/* File: verif/mpw_bridge_model.sv */
// half-bridge gate driver pair model for the four pwm pin pairs
// assumes: pin 2g drives the high switch, 2g+1 the low switch of leg g
`timescale 1ns/10ps
`default_nettype none
module mpw_bridge_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] gate,
    output logic [3:0] shoot
);
    // sticky: one overlap cycle would already short the supply
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shoot <= 4'h0;
        else
            for (int g = 0; g < 4; g++)
                if (gate[2*g] && gate[2*g+1])
                    shoot[g] <= 1'b1;
    end
endmodule // mpw_bridge_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the pwm unit top
// assumes: apb slave answers within 20 cycles, gate driver model on pins
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct {logic [11:0] a; logic [31:0] w, r; logic e;} mpw_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, irq, er;
    logic [3:0] fault_in = 0, adc_trig, shoot;
    logic [7:0] pwm_out;
    wire logic [12:0] mon;
    int err_total = 0, checks_done = 0;
    mpw_row_t rows[8] = '{
        '{12'h00c, 32'h0000_00ff, 32'h0000_00ff, 0},
        '{12'h010, 32'hffff_ffa5, 32'h0000_00a5, 0},
        '{12'h018, 32'h0000_003c, 32'h0000_003c, 0},
        '{12'h004, 32'h0000_0000, 32'h0000_0000, 0},
        '{12'h144, 32'h0000_1234, 32'h0000_1234, 0},
        '{12'h188, 32'h0000_beef, 32'h0000_beef, 0},
        '{12'h034, 32'h0000_0005, 32'h0000_0000, 1},
        '{12'h124, 32'h0000_0007, 32'h0000_0000, 1}};
    assign mon = {adc_trig, irq, pwm_out};
    always #20 pclk = ~pclk;
    mpw_top i_dut(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_in(fault_in), .pwm_out(pwm_out), .adc_trig(adc_trig),
        .irq(irq));
    mpw_bridge_model i_load(.pclk(pclk), .presetn(presetn),
        .gate(pwm_out), .shoot(shoot));
    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1)
        begin
            chk({31'h0, pready}, 32'h1);
            tally_and_finish();
        end
    endtask
    task automatic wait_on(input int i, input logic v);
        int n;
        n = 0;
        while (mon[i] !== v && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, mon[i]}, {31'h0, v});
        if (mon[i] !== v)
            tally_and_finish();
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        chk({19'h0, mon}, 32'h0);
        presetn <= 1;
        foreach (rows[k])
        begin
            apb(1, rows[k].a, rows[k].w);
            chk({31'h0, er}, {31'h0, rows[k].e});
            apb(0, rows[k].a, 32'h0);
            chk(rd, rows[k].r);
            chk({31'h0, er}, {31'h0, rows[k].e});
        end
        // gen 0: down count, load 3 (period 4 cycles), zero action drives A high
        apb(1, 12'h010, 32'h0);
        apb(1, 12'h018, 32'h0);
        apb(1, 12'h104, 32'h3);
        apb(1, 12'h110, 32'h3);
        apb(1, 12'h118, 32'h0202);
        apb(1, 12'h100, 32'h11);
        apb(1, 12'h00c, 32'h3);
        repeat (6)
        begin
            apb(0, 12'h120, 32'h0);
            chk(rd > 32'h3 ? 32'h1 : 32'h0, 32'h0);
        end
        wait_on(0, 1);
        chk({30'h0, pwm_out[1:0]}, 32'h1);
        apb(1, 12'h010, 32'h1);
        wait_on(0, 0);
        // fault on pin 0: safe level 1 must beat the inversion
        apb(1, 12'h014, 32'h1);
        apb(1, 12'h018, 32'h1);
        apb(1, 12'h020, 32'h1);
        apb(1, 12'h02c, 32'h10);
        fault_in <= 4'h1;
        wait_on(0, 1);
        wait_on(8, 1);
        apb(0, 12'h028, 32'h0);
        chk(rd & 32'h10, 32'h10);
        fault_in <= 4'h0;
        wait_on(0, 0);
        apb(1, 12'h02c, 32'h0);
        wait_on(8, 0);
        apb(1, 12'h02c, 32'h10);
        wait_on(8, 1);
        apb(1, 12'h028, 32'h10);
        wait_on(8, 0);
        apb(0, 12'h028, 32'h0);
        chk(rd & 32'h10, 32'h0);
        // inverted fault polarity: idle low pin now counts as fault
        apb(1, 12'h01c, 32'h1);
        wait_on(0, 1);
        apb(1, 12'h00c, 32'h0);
        wait_on(0, 0);
        // gen 1 up/down: deferred load applied at zero under grouped arm
        apb(1, 12'h140, 32'h6);
        apb(1, 12'h144, 32'h5);
        apb(1, 12'h148, 32'h2);
        apb(1, 12'h150, 32'hb0);
        apb(1, 12'h15c, 32'h0102);
        apb(1, 12'h11c, 32'h1);
        apb(1, 12'h02c, 32'h2);
        apb(1, 12'h00c, 32'h4);
        apb(1, 12'h000, 32'h2);
        apb(1, 12'h008, 32'h2);
        apb(0, 12'h008, 32'h0);
        chk(rd, 32'h2);
        apb(1, 12'h140, 32'h7);
        wait_on(10, 1);
        wait_on(10, 0);
        apb(0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        wait_on(2, 1);
        // falls only if the count turns at the new load of 5
        wait_on(2, 0);
        wait_on(8, 1);
        apb(0, 12'h028, 32'h0);
        chk(rd & 32'hf, 32'h3);
        apb(1, 12'h004, 32'h2);
        apb(0, 12'h160, 32'h0);
        chk(rd, 32'h0);
        // extended mode: paused gen 1 still applies at gen 0 zero
        apb(1, 12'h140, 32'h6);
        apb(1, 12'h000, 32'h12);
        apb(1, 12'h008, 32'h3);
        repeat (8) @(posedge pclk);
        apb(0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        chk({28'h0, shoot}, 32'h0);
        // mid-run reset: pins drop at once, OUTEN reads back its reset value
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({19'h0, mon}, 32'h0);
        presetn <= 1'b1;
        apb(0, 12'h00c, 32'h0);
        chk(rd, 32'h0);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
